// ---- src/dual_timebase_cc_array.sv ----
// Sixteen-channel capture/compare array on two reloadable timebases.
//
// Contract
// - Sixteen channels with one clock cycle timing resolution normally.
// - Staggered mode slows channel resolution to eight clock cycles.
// - Two independent 16-bit timebases, each with its own reload register.
// - Timebase clock from prescaled system clock or general timer overflows.
// - External count input advances a timebase; outside party supplies pulses.
// - Sixteen registers, each on either timebase, capture or compare.
// - Each register owns one pin: capture trigger or compare output.
// - Capture copies the assigned timebase on the selected pin edge.
// - Every capture raises that channel's interrupt request.
// - Capture trigger is rising, falling or either pin edge.
// - Compare channels match continuously; equality fires the mode action.
// - Mode 0 interrupts only, pin untouched, many per period.
// - Mode 1 toggles the pin on every match, many per period.
// - Mode 2 interrupts only, at most once per timer period.
// - Mode 3 sets pin on match, clears on overflow, once per period.
// - Double-register pair shares one pin, toggled by either match.
// - Single-event option limits any mode to one edge or pulse.
`timescale 1ns/100ps
module dual_timebase_cc_array (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic reset_n,
	// Timebase control
	input cc_array_pkg::tb_cfg_s [cc_array_pkg::NUM_TB-1:0] tb_cfg,
	input wire logic stagger_en,
	input wire logic [cc_array_pkg::NUM_TB-1:0] tb_reload_wr,
	input wire logic [cc_array_pkg::TB_W-1:0] tb_reload_data,
	input wire logic general_timer_module_two_ovf,
	input wire logic ext_count_in,
	// Channel configuration
	input cc_array_pkg::cc_cfg_s [cc_array_pkg::NUM_CH-1:0] cc_cfg,
	input wire logic [cc_array_pkg::NUM_CH-1:0] cc_wr,
	input wire logic [cc_array_pkg::TB_W-1:0] cc_wdata,
	input wire logic [cc_array_pkg::NUM_CH/2-1:0] pair_dbl,
	input wire logic [cc_array_pkg::NUM_CH-1:0] se_rearm,
	// Channel pins
	input wire logic [cc_array_pkg::NUM_CH-1:0] cc_pin_in,
	output logic [cc_array_pkg::NUM_CH-1:0] cc_pin_out,
	output logic [cc_array_pkg::NUM_CH-1:0] cc_pin_oe,
	// Status
	output logic [cc_array_pkg::NUM_CH-1:0][cc_array_pkg::TB_W-1:0] cc_value,
	output logic [cc_array_pkg::NUM_CH-1:0] cc_irq,
	output logic [cc_array_pkg::NUM_TB-1:0][cc_array_pkg::TB_W-1:0] tb_value
);
	import cc_array_pkg::*;

	// ----------------------------------------------------------------
	// Declarations
	// ----------------------------------------------------------------
	logic [SYNC_W-1:0] sync_lvl;
	logic [SYNC_W-1:0] sync_lvl_d_r;
	logic ext_rise;
	logic [NUM_TB-1:0] tb_step;
	logic [NUM_TB-1:0] tb_ovf;
	logic [NUM_CH-1:0] hit_w;
	logic [NUM_CH-1:0] cap_w;
	logic [NUM_CH-1:0] ch_ovf_w;
	logic [NUM_CH-1:0] once_r;
	logic [NUM_CH-1:0] done_r;

	// ----------------------------------------------------------------
	// Input synchronisers and edge detection
	// ----------------------------------------------------------------
	pin_sync #(
		.W(SYNC_W)
	) u_sync (
		.ref_clk(ref_clk),
		.reset_n(reset_n),
		.async_in({ext_count_in, cc_pin_in}),
		.level(sync_lvl)
	);

	always_ff @(posedge ref_clk) begin
		if (!reset_n) begin
			sync_lvl_d_r <= '0;
		end else begin
			sync_lvl_d_r <= sync_lvl;
		end
	end

	assign ext_rise = sync_lvl[NUM_CH] && !sync_lvl_d_r[NUM_CH];

	// ----------------------------------------------------------------
	// Timebases
	// ----------------------------------------------------------------
	for (genvar t = 0; t < NUM_TB; t++) begin : g_tb
		cc_timebase u_tb (
			.ref_clk(ref_clk),
			.reset_n(reset_n),
			.cfg(tb_cfg[t]),
			.stagger_en(stagger_en),
			.gpt_ovf(general_timer_module_two_ovf),
			.ext_rise(ext_rise),
			.reload_wr(tb_reload_wr[t]),
			.reload_data(tb_reload_data),
			.value(tb_value[t]),
			.step(tb_step[t]),
			.ovf(tb_ovf[t])
		);
	end

	// ----------------------------------------------------------------
	// Per-channel events
	// ----------------------------------------------------------------
	for (genvar i = 0; i < NUM_CH; i++) begin : g_ev
		logic sel_w;
		logic cmp_w;
		logic once_mode_w;
		logic rise_w;
		logic fall_w;
		logic cap_l;

		assign sel_w = cc_cfg[i].tb_sel;
		assign cmp_w = cc_cfg[i].mode inside {CC_CMP0, CC_CMP1, CC_CMP2,
			CC_CMP3};
		assign once_mode_w = cc_cfg[i].mode inside {CC_CMP2, CC_CMP3};
		assign rise_w = sync_lvl[i] && !sync_lvl_d_r[i];
		assign fall_w = !sync_lvl[i] && sync_lvl_d_r[i];
		assign ch_ovf_w[i] = tb_ovf[sel_w];

		// A match counts only in the cycle after the timebase stepped.
		assign hit_w[i] = cmp_w && tb_step[sel_w]
			&& tb_value[sel_w] == cc_value[i]
			&& !done_r[i]
			&& !(once_mode_w && once_r[i]);

		always_comb begin
			cap_l = 1'b0;
			if (cc_cfg[i].mode == CC_CAPTURE && !done_r[i]) begin
				unique case (cc_cfg[i].edge_sel)
					EDGE_RISE: cap_l = rise_w;
					EDGE_FALL: cap_l = fall_w;
					EDGE_BOTH: cap_l = rise_w || fall_w;
					default: cap_l = 1'b0;
				endcase
			end
		end

		assign cap_w[i] = cap_l;
	end

	// ----------------------------------------------------------------
	// Capture/compare registers
	// ----------------------------------------------------------------
	always_ff @(posedge ref_clk) begin
		if (!reset_n) begin
			cc_value <= '0;
		end else begin
			for (int k = 0; k < NUM_CH; k++) begin
				if (cap_w[k]) begin
					cc_value[k] <= tb_value[cc_cfg[k].tb_sel];
				end else if (cc_wr[k]) begin
					cc_value[k] <= cc_wdata;
				end
			end
		end
	end

	// ----------------------------------------------------------------
	// Interrupt requests
	// ----------------------------------------------------------------
	always_ff @(posedge ref_clk) begin
		if (!reset_n) begin
			cc_irq <= '0;
		end else begin
			cc_irq <= cap_w | hit_w;
		end
	end

	// ----------------------------------------------------------------
	// Once-per-period and single-event flags
	// ----------------------------------------------------------------
	always_ff @(posedge ref_clk) begin
		if (!reset_n) begin
			once_r <= '0;
		end else begin
			for (int k = 0; k < NUM_CH; k++) begin
				if (hit_w[k]) begin
					once_r[k] <= 1'b1;
				end else if (ch_ovf_w[k]) begin
					once_r[k] <= 1'b0;
				end
			end
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!reset_n) begin
			done_r <= '0;
		end else begin
			for (int k = 0; k < NUM_CH; k++) begin
				if (cc_cfg[k].single && (hit_w[k] || cap_w[k])) begin
					done_r[k] <= 1'b1;
				end else if (se_rearm[k]) begin
					done_r[k] <= 1'b0;
				end
			end
		end
	end

	// ----------------------------------------------------------------
	// Pin drivers
	// ----------------------------------------------------------------
	for (genvar p = 0; p < NUM_CH; p++) begin : g_pin
		localparam int PAIR = p / 2;
		localparam bit EVEN = (p % 2) == 0;
		logic dbl_w;
		logic toggle_w;

		assign dbl_w = pair_dbl[PAIR];
		if (EVEN) begin : g_even
			// Either channel of the pair toggles the shared pin.
			assign toggle_w = dbl_w ? (hit_w[p] || hit_w[p+1])
				: (hit_w[p] && cc_cfg[p].mode == CC_CMP1);
		end else begin : g_odd
			assign toggle_w = !dbl_w && hit_w[p]
				&& cc_cfg[p].mode == CC_CMP1;
		end

		always_ff @(posedge ref_clk) begin
			if (!reset_n) begin
				cc_pin_out[p] <= 1'b0;
			end else if (toggle_w) begin
				cc_pin_out[p] <= !cc_pin_out[p];
			end else if (cc_cfg[p].mode == CC_CMP3 && !(dbl_w && !EVEN)) begin
				if (hit_w[p]) begin
					cc_pin_out[p] <= 1'b1;
				end else if (ch_ovf_w[p]) begin
					cc_pin_out[p] <= 1'b0;
				end
			end
		end

		// Only modes 1 and 3 and the even pin of a double pair drive; other modes and the odd pin of a pair release.
		always_ff @(posedge ref_clk) begin
			if (!reset_n) begin
				cc_pin_oe[p] <= 1'b0;
			end else if (dbl_w) begin
				cc_pin_oe[p] <= EVEN;
			end else begin
				cc_pin_oe[p] <= cc_cfg[p].mode inside {CC_CMP1, CC_CMP3};
			end
		end
	end

endmodule : dual_timebase_cc_array

// ---- src/cc_array_pkg.sv ----
// Shared constants and types of the dual timebase capture/compare array.
package cc_array_pkg;

	// ----------------------------------------------------------------
	// Sizes
	// ----------------------------------------------------------------
	localparam int NUM_CH = 16;
	localparam int NUM_TB = 2;
	localparam int TB_W = 16;
	localparam int PRE_W = 11;
	localparam int SYNC_W = NUM_CH + 1;

	// ----------------------------------------------------------------
	// Counts and reset values
	// ----------------------------------------------------------------
	localparam logic [PRE_W-1:0] DIV_NORMAL = 11'h001;
	localparam logic [PRE_W-1:0] DIV_STAGGER = 11'h008;
	localparam logic [TB_W-1:0] TB_MAX = 16'hFFFF;
	localparam logic [TB_W-1:0] TB_RESET = 16'h0000;
	localparam logic [TB_W-1:0] RELOAD_RESET = 16'h0000;
	localparam logic [TB_W-1:0] CC_RESET = 16'h0000;

	// ----------------------------------------------------------------
	// Modes and configuration
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {SRC_PRESCALE, SRC_GPT, SRC_EXT} tb_src_e;
	typedef enum logic [2:0] {
		CC_OFF, CC_CAPTURE, CC_CMP0, CC_CMP1, CC_CMP2, CC_CMP3
	} cc_mode_e;
	typedef enum logic [1:0] {EDGE_RISE, EDGE_FALL, EDGE_BOTH} edge_sel_e;

	typedef struct packed {
		logic run;
		tb_src_e src;
		logic [2:0] prescale;
	} tb_cfg_s;

	typedef struct packed {
		logic tb_sel;
		cc_mode_e mode;
		edge_sel_e edge_sel;
		logic single;
	} cc_cfg_s;

endpackage : cc_array_pkg

// ---- src/pin_sync.sv ----
// Three-stage synchroniser whose level changes once stages two and three agree.
`timescale 1ns/100ps
module pin_sync #(
	parameter int W = 1
) (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic reset_n,
	// Asynchronous inputs and filtered levels
	input wire logic [W-1:0] async_in,
	output logic [W-1:0] level
);

	logic [W-1:0] s1_r;
	logic [W-1:0] s2_r;
	logic [W-1:0] s3_r;

	always_ff @(posedge ref_clk) begin
		if (!reset_n) begin
			s1_r <= '0;
			s2_r <= '0;
			s3_r <= '0;
		end else begin
			s1_r <= async_in;
			s2_r <= s1_r;
			s3_r <= s2_r;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!reset_n) begin
			level <= '0;
		end else begin
			for (int k = 0; k < W; k++) begin
				if (s2_r[k] == s3_r[k]) begin
					level[k] <= s3_r[k];
				end
			end
		end
	end

endmodule : pin_sync

// ---- src/cc_timebase.sv ----
// One 16-bit up-counting timebase with prescaler and reload register.
`timescale 1ns/100ps
module cc_timebase
	import cc_array_pkg::*;
(
	// Clock and reset
	input wire logic ref_clk,
	input wire logic reset_n,
	// Control
	input cc_array_pkg::tb_cfg_s cfg,
	input wire logic stagger_en,
	input wire logic gpt_ovf,
	input wire logic ext_rise,
	input wire logic reload_wr,
	input wire logic [cc_array_pkg::TB_W-1:0] reload_data,
	// Timer state
	output logic [cc_array_pkg::TB_W-1:0] value,
	output logic step,
	output logic ovf
);

	logic [PRE_W-1:0] pre_r;
	logic [PRE_W-1:0] div_w;
	logic [TB_W-1:0] reload_r;
	logic tick_w;

	assign div_w = (stagger_en ? DIV_STAGGER : DIV_NORMAL) << cfg.prescale;

	always_comb begin
		tick_w = 1'b0;
		if (cfg.run) begin
			unique case (cfg.src)
				SRC_PRESCALE: tick_w = (pre_r == div_w - DIV_NORMAL);
				SRC_GPT: tick_w = gpt_ovf;
				SRC_EXT: tick_w = ext_rise;
				default: tick_w = 1'b0;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Prescaler
	// ----------------------------------------------------------------
	always_ff @(posedge ref_clk) begin
		if (!reset_n || !cfg.run || pre_r >= div_w - DIV_NORMAL) begin
			pre_r <= '0;
		end else begin
			pre_r <= pre_r + DIV_NORMAL;
		end
	end

	// ----------------------------------------------------------------
	// Reload register and counter
	// ----------------------------------------------------------------
	always_ff @(posedge ref_clk) begin
		if (!reset_n) begin
			reload_r <= RELOAD_RESET;
		end else if (reload_wr) begin
			reload_r <= reload_data;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!reset_n) begin
			value <= TB_RESET;
			step <= 1'b0;
			ovf <= 1'b0;
		end else begin
			step <= tick_w;
			ovf <= tick_w && value == TB_MAX;
			if (tick_w) begin
				value <= (value == TB_MAX) ? reload_r : value + 16'h0001;
			end
		end
	end

endmodule : cc_timebase

// ---- sim/dual_timebase_cc_array_monitor.sv ----
// Port assertions and covers for the capture/compare array.
`timescale 1ns/100ps
module cc_array_monitor
	import cc_array_pkg::*;
(
	// Clock and reset
	input wire logic ref_clk,
	input wire logic reset_n,
	// Watched ports
	input cc_array_pkg::tb_cfg_s [1:0] tb_cfg,
	input wire logic stagger_en,
	input cc_array_pkg::cc_cfg_s [15:0] cc_cfg,
	input wire logic [15:0] cc_pin_out,
	input wire logic [15:0] cc_pin_oe,
	input wire logic [15:0][15:0] cc_value,
	input wire logic [15:0] cc_irq,
	input wire logic [1:0][15:0] tb_value
);
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!reset_n);
	logic pre0;
	assign pre0 = tb_cfg[0].run && tb_cfg[0].src == SRC_PRESCALE
		&& tb_cfg[0].prescale == 3'h0;
	AST_TB_STEP: assert property (
		$changed(tb_value[0]) |-> $past(tb_value[0]) == 16'hFFFF
		|| tb_value[0] == 16'($past(tb_value[0]) + 16'h0001))
		else $error("timebase moved by other than one step");
	AST_RUN_HOLD: assert property (
		!$past(tb_cfg[1].run) |-> $stable(tb_value[1]))
		else $error("stopped timebase changed");
	AST_STAGGER: assert property (
		$changed(tb_value[0]) && pre0 && stagger_en && $past(stagger_en)
		|=> $stable(tb_value[0]) [*7])
		else $error("staggered timebase stepped too soon");
	AST_CAPTURE: assert property (
		cc_irq[0] && cc_cfg[0].mode == CC_CAPTURE && !cc_cfg[0].tb_sel
		|-> cc_value[0] == $past(tb_value[0]))
		else $error("captured value differs from timebase");
	AST_CMP0_PIN: assert property (
		cc_irq[2] && cc_cfg[2].mode == CC_CMP0
		|-> !cc_pin_oe[2] && $stable(cc_pin_out[2]))
		else $error("interrupt only compare touched its pin");
	AST_CMP1_TOGGLE: assert property (
		cc_irq[3] && cc_cfg[3].mode == CC_CMP1
		|-> cc_pin_out[3] != $past(cc_pin_out[3]))
		else $error("toggle compare did not invert its pin");
	AST_CMP3_SET: assert property (
		cc_irq[5] && cc_cfg[5].mode == CC_CMP3
		|-> cc_pin_out[5] && cc_pin_oe[5])
		else $error("set compare did not drive its pin high");
	AST_CMP3_CLR: assert property (
		cc_cfg[5].mode == CC_CMP3 && $past(tb_value[0]) == 16'hFFFF
		&& $changed(tb_value[0]) |-> ##[0:1] !cc_pin_out[5])
		else $error("set compare pin not cleared on overflow");
	cover property (cc_irq[0]);
	cover property (cc_irq[3] && cc_pin_out[3]);
	cover property (cc_irq[5]);
endmodule : cc_array_monitor

bind dual_timebase_cc_array cc_array_monitor mon (.ref_clk, .reset_n,
	.tb_cfg, .stagger_en, .cc_cfg, .cc_pin_out, .cc_pin_oe, .cc_value,
	.cc_irq, .tb_value);

// ---- sim/cc_pin_partner.sv ----
// Model of the signal sources and loads on the channel pins.
`timescale 1ns/100ps
module cc_pin_partner (
	// Clock
	input wire logic ref_clk,
	// Pin wires
	input wire logic [15:0] cc_pin_out,
	input wire logic [15:0] cc_pin_oe,
	output logic [15:0] cc_pin_in,
	output logic ext_count_in
);
	logic [15:0] drv_r = 16'h0000;
	initial ext_count_in = 1'b0;
	// A driven pin reads back the device level, otherwise the source level.
	assign cc_pin_in = (cc_pin_oe & cc_pin_out) | (~cc_pin_oe & drv_r);
	task automatic set_pin(input int ch, input logic v);
		@(posedge ref_clk);
		#1 drv_r[ch] = v;
	endtask : set_pin
	// Count pulses are four cycles high and four low.
	task automatic ext_pulses(input int n);
		repeat (n) begin
			@(posedge ref_clk);
			#1 ext_count_in = 1'b1;
			repeat (4) @(posedge ref_clk);
			#1 ext_count_in = 1'b0;
			repeat (3) @(posedge ref_clk);
		end
	endtask : ext_pulses
endmodule : cc_pin_partner

// ---- sim/dual_timebase_cc_array_test.sv ----
// Self-checking bench for the dual timebase capture/compare array.
`timescale 1ns/100ps
module dual_timebase_cc_array_test;
	import cc_array_pkg::*;
	localparam logic [15:0] RLD = 16'hFFF0;
	logic ref_clk = 1'b0;
	logic reset_n = 1'b0;
	tb_cfg_s [1:0] tb_cfg = '0;
	logic stagger_en = 1'b0;
	logic [1:0] tb_reload_wr = '0;
	logic [15:0] tb_reload_data = '0;
	logic gpt_ovf = 1'b0;
	logic ext_count_in;
	cc_cfg_s [15:0] cc_cfg = '0;
	logic [15:0] cc_wr = '0;
	logic [15:0] cc_wdata = '0;
	logic [7:0] pair_dbl = '0;
	logic [15:0] se_rearm = '0;
	logic [15:0] cc_pin_in, cc_pin_out, cc_pin_oe, cc_irq;
	logic [15:0][15:0] cc_value;
	logic [1:0][15:0] tb_value;
	int err_total = 0;
	int comparisons = 0;
	int irqs[16];
	int togs[16];
	int tbch;
	always #2.5 ref_clk = ~ref_clk;
	dual_timebase_cc_array dut (.ref_clk, .reset_n, .tb_cfg, .stagger_en,
		.tb_reload_wr, .tb_reload_data, .general_timer_module_two_ovf(gpt_ovf),
		.ext_count_in, .cc_cfg, .cc_wr, .cc_wdata, .pair_dbl,
		.se_rearm, .cc_pin_in, .cc_pin_out, .cc_pin_oe, .cc_value,
		.cc_irq, .tb_value);
	cc_pin_partner pin (.ref_clk, .cc_pin_out, .cc_pin_oe, .cc_pin_in,
		.ext_count_in);
	// ----
	// Helpers
	// ----
	task automatic complete_run;
		$display("comparisons %0d mismatches %0d", comparisons, err_total);
		if (err_total == 0 && comparisons > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : complete_run
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		comparisons++;
		if (got !== exp) begin
			err_total++;
			$display("MISMATCH t=%0t seen=%h expected=%h", $time, got, exp);
		end
	endtask : chk
	task automatic cyc(input int n);
		repeat (n) @(posedge ref_clk);
		#1;
	endtask : cyc
	task automatic wr(input int ch, input logic [15:0] v);
		cyc(1);
		cc_wdata = v;
		cc_wr[ch] = 1'b1;
		cyc(1);
		cc_wr = '0;
	endtask : wr
	function automatic logic [15:0] adv(input logic [15:0] v, input int n);
		repeat (n) v = (v == TB_MAX) ? RLD : v + 16'h0001;
		return v;
	endfunction : adv
	// Counts interrupts, pin changes and timebase steps over n cycles.
	task automatic watch(input int n);
		logic [15:0] prev;
		logic [15:0] pv;
		irqs = '{default: 0};
		togs = '{default: 0};
		tbch = 0;
		prev = tb_value[0];
		pv = cc_pin_out;
		repeat (n) begin
			cyc(1);
			if (cc_irq[0] === 1'b1 && cc_cfg[0].mode == CC_CAPTURE)
				chk(cc_value[0], prev);
			for (int i = 0; i < 16; i++) begin
				irqs[i] += int'(cc_irq[i] === 1'b1);
				togs[i] += int'(cc_pin_out[i] !== pv[i]);
			end
			tbch += int'(tb_value[0] !== prev);
			prev = tb_value[0];
			pv = cc_pin_out;
		end
	endtask : watch
	// ----
	// Scenarios
	// ----
	task automatic s_wrap;
		int k;
		chk(tb_value[0] | cc_irq | cc_pin_oe, 16'h0000);
		tb_reload_data = RLD;
		tb_reload_wr = 2'b11;
		cyc(1);
		tb_reload_wr = 2'b00;
		tb_cfg[0] = '{1'b1, SRC_PRESCALE, 3'h0};
		tb_cfg[1] = '{1'b1, SRC_PRESCALE, 3'h0};
		for (k = 0; k < 70000 && tb_value[0] !== TB_MAX; k++)
			cyc(1);
		if (k >= 70000) begin
			err_total++;
			complete_run();
		end
		cyc(1);
		chk(tb_value[0], RLD);
		chk(tb_value[1], RLD);
	endtask : s_wrap
	task automatic s_ext;
		logic [15:0] v;
		tb_cfg[1].src = SRC_EXT;
		cyc(2);
		v = tb_value[1];
		pin.ext_pulses(3);
		cyc(8);
		chk(tb_value[1], adv(v, 3));
		tb_cfg[1].src = SRC_GPT;
		cyc(2);
		v = tb_value[1];
		gpt_ovf = 1'b1;
		cyc(2);
		gpt_ovf = 1'b0;
		cyc(2);
		chk(tb_value[1], adv(v, 2));
		tb_cfg[1].run = 1'b0;
		cyc(1);
		gpt_ovf = 1'b1;
		cyc(2);
		gpt_ovf = 1'b0;
		cyc(2);
		chk(tb_value[1], adv(v, 2));
	endtask : s_ext
	task automatic s_capture;
		int n;
		cc_cfg[0].mode = CC_CAPTURE;
		for (int i = 0; i < 3; i++) begin
			cc_cfg[0].edge_sel = edge_sel_e'(i);
			pin.set_pin(0, 1'b1);
			watch(12);
			n = irqs[0];
			pin.set_pin(0, 1'b0);
			watch(12);
			chk(16'(n), (i == 1) ? 16'h0000 : 16'h0001);
			chk(16'(irqs[0]), (i == 0) ? 16'h0000 : 16'h0001);
		end
	endtask : s_capture
	task automatic s_compare;
		int k;
		pair_dbl = 8'h10;
		for (int c = 2; c <= 6; c++)
			wr(c, 16'hFFF4);
		wr(8, 16'hFFF2);
		wr(9, 16'hFFF8);
		for (int c = 2; c <= 5; c++)
			cc_cfg[c].mode = cc_mode_e'(c);
		cc_cfg[6] = '{1'b0, CC_CMP1, EDGE_RISE, 1'b1};
		cc_cfg[8].mode = CC_CMP1;
		cc_cfg[9].mode = CC_CMP1;
		watch(48);
		for (int c = 2; c <= 5; c++)
			chk(16'(irqs[c]), 16'h0003);
		chk(16'(togs[2]), 16'h0000);
		chk(16'(togs[3]), 16'h0003);
		chk(16'(irqs[6] + togs[6]), 16'h0002);
		chk(16'(togs[8]), 16'h0006);
		se_rearm[6] = 1'b1;
		cyc(1);
		se_rearm = '0;
		watch(16);
		chk(16'(togs[6]), 16'h0001);
		chk(cc_pin_oe & 16'h033C, 16'h0128);
		for (k = 0; k < 20 && cc_irq[4] !== 1'b1; k++)
			cyc(1);
		if (k >= 20) begin
			err_total++;
			complete_run();
		end
		wr(4, 16'hFFFD);
		wr(2, 16'hFFFD);
		watch(7);
		chk(16'(irqs[2] * 2 + irqs[4]), 16'h0002);
	endtask : s_compare
	task automatic s_stagger;
		stagger_en = 1'b1;
		cyc(16);
		watch(64);
		chk(16'(tbch), 16'h0008);
		stagger_en = 1'b0;
		cyc(4);
		watch(64);
		chk(16'(tbch), 16'h0040);
	endtask : s_stagger
	initial begin
		cyc(10);
		reset_n = 1'b1;
		cyc(1);
		s_wrap();
		s_ext();
		s_capture();
		s_compare();
		s_stagger();
		complete_run();
	end
endmodule : dual_timebase_cc_array_test
